//--- core/pbs_params.svh
// constants for the pattern buffer side-band signalling block
// assumes inclusion from the package and the core module only
`ifndef PBS_PARAMS_SVH
`define PBS_PARAMS_SVH

// -----------------------------------------------------------------
// target addresses chosen by the strap
// -----------------------------------------------------------------
`define PBS_ADDR_STRAP_LOW  7'h1b
`define PBS_ADDR_STRAP_HIGH 7'h1d

// -----------------------------------------------------------------
// reset values and widths
// -----------------------------------------------------------------
`define PBS_INDEX_RESET     2'h0
`define PBS_BUFFER_COUNT    3'h4
`define PBS_ADVANCE_PULSE   4'h2
// edges after release before the synchronised strap holds the pin value
`define PBS_STRAP_SETTLE    2'h2

`endif

//--- core/pbs_pkg.sv
// types shared by the pattern buffer side-band signalling block
// assumes pbs_params.svh sits beside it
`include "pbs_params.svh"

package pbs_pkg;
	typedef enum logic [1:0] {
		PBS_STRAP   = 2'b00,
		PBS_HOLDLOW = 2'b01,
		PBS_ACTIVE  = 2'b10
	} pbs_pin_e;

	typedef struct packed {
		logic [1:0] bufferIndex;
		logic       bufferAdvance;
		logic       patternInvert;
	} pbs_side_s;

	typedef struct packed {
		logic [1:0] out;
		logic [1:0] oe;
	} pbs_index_pins_s;
endpackage

//--- core/pbs_pattern_buffer_signalling.sv
// side-band pins toward an optional companion logic holding four buffers
// assumes display core events come from logic on clk; strap and load-done come from pins
//
// What this block does
// - asserting invert makes the held one-bit pattern display inverted.
// - after configuration load, invert, index and advance drive low, not enabled.
// - host enables outputs by control register write; device keeps them inactive until.
// - two index outputs encode which of four buffers is in use.
// - strap sampled once at reset release to choose target address.
// - strap low gives address 1Bh, strap high gives 1Dh.
// - upper index pin is input at reset release, low output after load.
// - advance output tells companion when to move to the next buffer.
`timescale 1ns/1ps
`default_nettype none
`include "pbs_params.svh"

module pbs_pattern_buffer_signalling (
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    reset,
	// configuration status and host control
	input  wire logic                    configLoadDone,
	input  wire logic                    outputsEnableWrite,
	input  wire logic                    outputsEnableValue,
	// display core events
	input  wire logic                    advanceRequest,
	input  wire logic                    invertRequest,
	input  wire logic                    pixelIn,
	// strap / upper index pin
	input  wire logic                    addrSelPinIn,
	// side-band pins
	output logic                         bufferIndexLsb,
	output logic                         bufferIndexLsbOe,
	output pbs_pkg::pbs_index_pins_s     indexPins,
	output logic                         bufferAdvance,
	output logic                         patternInvert,
	// results
	output logic [6:0]                   targetAddress,
	output logic                         pixelOut,
	output pbs_pkg::pbs_side_s           sideState
);
	import pbs_pkg::*;

	// -----------------------------------------------------------------
	// input synchronisers
	// -----------------------------------------------------------------
	logic strapMeta_ff;
	logic strapSync_ff;
	logic loadMeta_ff;
	logic loadSync_ff;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			strapMeta_ff <= 1'b0;
			strapSync_ff <= 1'b0;
			loadMeta_ff  <= 1'b0;
			loadSync_ff  <= 1'b0;
		end else begin
			strapMeta_ff <= addrSelPinIn;
			strapSync_ff <= strapMeta_ff;
			loadMeta_ff  <= configLoadDone;
			loadSync_ff  <= loadMeta_ff;
		end
	end

	// -----------------------------------------------------------------
	// pin state sequencing
	// -----------------------------------------------------------------
	pbs_pin_e pinState_ff;
	pbs_pin_e nxt_pinState;
	logic     strapTaken_ff;
	logic     enabled_ff;

	always_comb begin
		nxt_pinState = pinState_ff;
		unique case (pinState_ff)
			PBS_STRAP:   if (strapTaken_ff && loadSync_ff) nxt_pinState = PBS_HOLDLOW;
			PBS_HOLDLOW: if (enabled_ff) nxt_pinState = PBS_ACTIVE;
			PBS_ACTIVE:  if (!enabled_ff) nxt_pinState = PBS_HOLDLOW;
			default:     nxt_pinState = PBS_HOLDLOW;
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			pinState_ff <= PBS_STRAP;
		else
			pinState_ff <= nxt_pinState;
	end

	// enable register bit, written by the host control path
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			enabled_ff <= 1'b0;
		else if (outputsEnableWrite && pinState_ff != PBS_STRAP)
			enabled_ff <= outputsEnableValue;
	end

	// -----------------------------------------------------------------
	// strap capture, once after release, from the synchronised pin
	// -----------------------------------------------------------------
	logic       strapValue_ff;
	logic [1:0] strapWait_ff;

	// sync delay means the capture waits two edges after release
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			strapWait_ff <= 2'h0;
		else if (strapWait_ff != 2'h3)
			strapWait_ff <= strapWait_ff + 2'h1;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			strapTaken_ff <= 1'b0;
			strapValue_ff <= 1'b0;
		end else if (!strapTaken_ff && strapWait_ff == `PBS_STRAP_SETTLE) begin
			strapTaken_ff <= 1'b1;
			strapValue_ff <= strapSync_ff;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			targetAddress <= `PBS_ADDR_STRAP_LOW;
		else if (!strapTaken_ff && strapWait_ff == `PBS_STRAP_SETTLE)
			targetAddress <= strapSync_ff ? `PBS_ADDR_STRAP_HIGH : `PBS_ADDR_STRAP_LOW;
	end

	// -----------------------------------------------------------------
	// buffer index and advance
	// -----------------------------------------------------------------
	logic [1:0] index_ff;
	logic [3:0] advCount_ff;
	logic       invert_ff;
	logic       active;

	assign active = (pinState_ff == PBS_ACTIVE);

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			index_ff <= `PBS_INDEX_RESET;
		else if (active && advanceRequest)
			index_ff <= index_ff + 2'h1; // wraps over four buffers
	end

	// advance held a few cycles so the companion's synchroniser sees it
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			advCount_ff <= 4'h0;
		else if (active && advanceRequest)
			advCount_ff <= `PBS_ADVANCE_PULSE;
		else if (!active)
			advCount_ff <= 4'h0;
		else if (advCount_ff != 4'h0)
			advCount_ff <= advCount_ff - 4'h1;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			invert_ff <= 1'b0;
		else
			invert_ff <= active && invertRequest;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			pixelOut <= 1'b0;
		else
			pixelOut <= pixelIn ^ invert_ff;
	end

	// -----------------------------------------------------------------
	// pin drivers
	// -----------------------------------------------------------------
	always_comb begin
		sideState.bufferIndex   = active ? index_ff : 2'h0;
		sideState.bufferAdvance = active && (advCount_ff != 4'h0);
		sideState.patternInvert = active && invert_ff;
	end

	assign bufferIndexLsb   = sideState.bufferIndex[0];
	assign bufferIndexLsbOe = (pinState_ff != PBS_STRAP);
	assign indexPins        = {sideState.bufferIndex, {2{pinState_ff != PBS_STRAP}}};
	assign bufferAdvance    = sideState.bufferAdvance;
	assign patternInvert    = sideState.patternInvert;

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	a_strap_input_phase: assert property (@(posedge clk) disable iff (reset)
		(pinState_ff == PBS_STRAP) |-> (indexPins.oe == 2'b00))
		else $error("upper index pin driven before load");
	a_low_before_enable: assert property (@(posedge clk) disable iff (reset)
		(!enabled_ff) |=> (!bufferAdvance && !patternInvert && indexPins.out == 2'h0))
		else $error("outputs active without enable");
	a_holdlow_after_load: assert property (@(posedge clk) disable iff (reset)
		(pinState_ff == PBS_HOLDLOW) |-> (indexPins.oe == 2'b11 && indexPins.out == 2'h0))
		else $error("pins not driven low after load");
	a_index_steps: assert property (@(posedge clk) disable iff (reset)
		(active && advanceRequest) |=> (index_ff == $past(index_ff) + 2'h1))
		else $error("index did not step");
	a_advance_pulse: assert property (@(posedge clk) disable iff (reset)
		(active && advanceRequest) ##1 active |-> bufferAdvance)
		else $error("advance not raised");
	a_invert_pixel: assert property (@(posedge clk) disable iff (reset)
		(patternInvert) |=> (pixelOut == !$past(pixelIn)))
		else $error("pixel not inverted");
	a_strap_once: assert property (@(posedge clk) disable iff (reset)
		strapTaken_ff |=> ($stable(strapValue_ff) && strapTaken_ff))
		else $error("strap resampled");
	a_address_pick: assert property (@(posedge clk) disable iff (reset)
		(strapWait_ff == 2'h3) |-> (targetAddress == (strapValue_ff ? 7'h1d : 7'h1b)))
		else $error("wrong target address");
endmodule // pbs_pattern_buffer_signalling
`default_nettype wire

//--- sim/pbs_companion_model.sv
// companion logic model: synchronises side-band pins, tracks the pointer
// assumes the pins reach it asynchronously and are resolved by the bench
`timescale 1ns/1ps
`default_nettype none
module pbs_companion_model (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset,
	// side-band pins
	input  wire logic [1:0] indexIn,
	input  wire logic       advanceIn,
	input  wire logic       invertIn,
	// observed state
	output logic [1:0]      readPtr_ff,
	output logic [7:0]      advCnt_ff,
	output logic            invert_ff
);
	logic [3:0] s1_ff;
	logic       advPrev_ff;
	// two stages before use except the advance edge, which is taken from the first stage; pins are async
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			{s1_ff, readPtr_ff, advPrev_ff, invert_ff} <= 8'h00;
			advCnt_ff <= 8'h00;
		end else begin
			s1_ff <= {indexIn, advanceIn, invertIn};
			{readPtr_ff, advPrev_ff, invert_ff} <= s1_ff;
			if (s1_ff[1] && !advPrev_ff)
				advCnt_ff <= advCnt_ff + 8'h01;
		end
	end
endmodule // pbs_companion_model
`default_nettype wire

//--- sim/tb.sv
// bench for the side-band signalling block with a companion model
// assumes the core files compile first
`timescale 1ns/1ps
`default_nettype none
module tb;
	import pbs_pkg::*;
	logic clk = 0, reset = 1, ldDone = 0, enWr = 0, enVal = 0;
	logic advReq = 0, invReq = 0, pixIn = 0, strap = 1, lsb, lsbOe, adv, inv, pixOut;
	pbs_index_pins_s idxPins;
	pbs_side_s       side;
	logic [6:0]      addr;
	logic [1:0]      rdPtr, expIdx;
	logic [7:0]      advCnt;
	logic            invSeen;
	int              error_cnt = 0, n_tests = 0, seed = 32'h049d, i;
	// pulled pins: strap resistor on the msb, pull-down on the lsb
	wire logic msb = idxPins.oe[1] ? idxPins.out[1] : strap;
	wire logic lsbPin = lsbOe ? lsb : 1'b0;
	always #12.5 clk = ~clk;
	pbs_pattern_buffer_signalling dut_u (.clk(clk), .reset(reset), .configLoadDone(ldDone),
		.outputsEnableWrite(enWr), .outputsEnableValue(enVal), .advanceRequest(advReq),
		.invertRequest(invReq), .pixelIn(pixIn), .addrSelPinIn(msb), .bufferIndexLsb(lsb),
		.bufferIndexLsbOe(lsbOe), .indexPins(idxPins), .bufferAdvance(adv), .patternInvert(inv),
		.targetAddress(addr), .pixelOut(pixOut), .sideState(side));
	pbs_companion_model cm_u (.clk(clk), .reset(reset), .indexIn({msb, lsbPin}), .advanceIn(adv),
		.invertIn(inv), .readPtr_ff(rdPtr), .advCnt_ff(advCnt), .invert_ff(invSeen));
	function automatic logic [6:0] expAddr(input logic s);
		return s ? 7'h1d : 7'h1b;
	endfunction
	task automatic step(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string nm);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic v);
		@(posedge clk) {enWr, enVal} <= {1'b1, v};
		@(posedge clk) enWr <= 1'b0;
		step(3);
	endtask
	task automatic tally_and_finish();
		if (error_cnt == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// --------------------------------
	// main sequence
	// --------------------------------
	initial begin
		step(12);
		cmp(addr, 7'h1b, "addr in reset");
		@(posedge clk) reset <= 1'b0;
		step(4);
		cmp(addr, expAddr(1'b1), "addr strap high");
		cmp(idxPins.oe[1], 0, "msb oe before load");
		@(posedge clk) strap <= 1'b0;
		step(4);
		cmp(addr, expAddr(1'b1), "addr after strap move");
		wr(1'b1);
		@(posedge clk) {ldDone, advReq, invReq} <= 3'b111;
		@(posedge clk) advReq <= 1'b0;
		step(4);
		cmp({idxPins.oe, lsbOe}, 3'h7, "oe after load");
		cmp({msb, lsbPin, adv, inv}, 0, "pins before enable");
		wr(1'b1);
		expIdx = 2'h0;
		for (i = 0; i < 24; i++) begin
			@(posedge clk) {advReq, invReq, pixIn} <= {1'b1, 2'($random(seed))};
			@(posedge clk) advReq <= 1'b0;
			@(posedge clk);
			@(negedge clk);
			expIdx = expIdx + 2'h1;
			cmp(adv, 1, "advance pulse");
			cmp({msb, lsbPin}, expIdx, "index pins");
			cmp({inv, pixOut}, {invReq, pixIn ^ invReq}, "invert");
			cmp(side, {expIdx, 1'b1, invReq}, "side state");
			step(4 + ($random(seed) & 3));
			cmp(rdPtr, expIdx, "companion pointer");
			cmp(advCnt, 8'(i + 1), "companion advances");
			cmp(invSeen, invReq, "companion invert");
		end
		wr(1'b0);
		cmp({msb, lsbPin, adv, inv}, 0, "pins after disable");
		@(posedge clk) reset <= 1'b1;
		step(2);
		@(posedge clk) {reset, ldDone} <= 2'b00;
		step(4);
		cmp(addr, expAddr(1'b0), "addr strap low");
		tally_and_finish();
	end
	initial begin
		#(25 * 4000);
		error_cnt++;
		tally_and_finish();
	end
endmodule // tb
`default_nettype wire
